// ===== verilog/lcdcd_top.sv
// lcd command decoder: ahb-lite register front end, command execution,
// display polarity, power circuit enables, power-save states
// assumes one zero-wait ahb-lite master; ram array lives outside
//
// Contract
// RULE_01: reverse bit flips pixel polarity, ram untouched
// RULE_02: all-on lights every pixel, ram kept
// RULE_03: all-on overrides reverse polarity
// RULE_04: bias bit picks ratio; fixed variants ignore
// RULE_05: bias accepted only while follower enabled
// RULE_06: rmw: reads hold column, writes advance
// RULE_07: rmw saves column; end restores, exits
// RULE_08: other commands accepted during rmw
// RULE_09: host ends rmw, no column sets inside
// RULE_10: soft reset clears line, column, page, scan
// RULE_11: soft reset leaves power state alone
// RULE_12: scan command uses bit 3 only
// RULE_13: power command loads follower, regulator, booster
// RULE_14: 5-bit contrast, zero disables control
// RULE_15: indicator changed only by its command
// RULE_16: indicator blinks about once per second
// RULE_17: all-on while display off enters power save
// RULE_18: sleep if indicator off, else standby
// RULE_19: sleep exit needs power-save-off and indicator on
// RULE_20: standby exit needs power-save-off
// RULE_21: sleep stops oscillator, supplies, drive
// RULE_22: soft reset in standby goes to sleep
// RULE_23: display on/off bit feeds power save test
// RULE_24: blink derived by dividing internal clock
module lcdcd_top
   import lcdcd_pkg::*;
#(
   parameter int unsigned BLINK_HALF = BLINK_HALF_CYC,
   parameter bit          BIAS_SEL_OK = 1'b1,
   parameter bit          SCAN_SEL_OK = 1'b1
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // ahb-lite slave
   input  wire logic        HSEL,
   input  wire logic [7:0]  HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HWDATA,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // display ram access
   output logic             RAM_WR_STB,
   output logic             RAM_RD_STB,
   output logic      [7:0]  RAM_WDATA,
   input  wire logic [7:0]  RAM_RDATA,
   output logic      [7:0]  RAM_COL,
   output logic      [3:0]  RAM_PAGE,
   output logic      [5:0]  START_LINE,
   // panel drive control
   output logic             PIXEL_INVERT,
   output logic             PIXEL_ALL_ON,
   output logic             DUTY_DRIVE_EN,
   output logic             COM_SCAN_REV,
   output logic             STATIC_IND_DRIVE,
   // power circuits
   output logic             OSC_EN,
   output logic             BOOSTER_EN,
   output logic             REGULATOR_EN,
   output logic             FOLLOWER_EN,
   output logic             BIAS_SEL,
   output logic      [4:0]  CONTRAST,
   output logic             CONTRAST_EN,
   output logic             SLEEP,
   output logic             STANDBY
);

   // bus address phase capture
   logic       sel_ff;
   logic       wr_ff;
   logic [7:0] addr_ff;

   always_ff @(posedge CLK) begin
      if (RST) begin
         sel_ff  <= 1'b0;
         wr_ff   <= 1'b0;
         addr_ff <= 8'h00;
      end else if (HREADY) begin
         sel_ff  <= HSEL && (HTRANS == TRANS_NONSEQ || HTRANS == TRANS_SEQ);
         wr_ff   <= HWRITE;
         addr_ff <= HADDR;
      end
   end

   // zero-wait slave, always okay
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   logic       wr_cmd;
   logic       wr_dat;
   logic       rd_dat;
   logic [7:0] cmd;

   assign wr_cmd = sel_ff && wr_ff && (addr_ff == OFS_CMD);
   assign wr_dat = sel_ff && wr_ff && (addr_ff == OFS_DATA);
   assign rd_dat = sel_ff && !wr_ff && (addr_ff == OFS_DATA);
   assign cmd    = HWDATA[7:0];

   // command decode
   logic is_disp, is_rev, is_all, is_bias, is_ind, is_rmw, is_end, is_srst;
   logic is_scan, is_page, is_colh, is_coll, is_pwr, is_ctr, is_line;

   assign is_disp = wr_cmd && cmd_hit(cmd, CMD_DISP, MSK_D0);
   assign is_rev  = wr_cmd && cmd_hit(cmd, CMD_REV, MSK_D0);
   assign is_all  = wr_cmd && cmd_hit(cmd, CMD_ALLON, MSK_D0);
   assign is_bias = wr_cmd && cmd_hit(cmd, CMD_BIAS, MSK_D0);
   assign is_ind  = wr_cmd && cmd_hit(cmd, CMD_IND, MSK_D0);
   assign is_rmw  = wr_cmd && cmd_hit(cmd, CMD_RMW, MSK_ALL);
   assign is_end  = wr_cmd && cmd_hit(cmd, CMD_END, MSK_ALL);
   assign is_srst = wr_cmd && cmd_hit(cmd, CMD_SRST, MSK_ALL);
   assign is_scan = wr_cmd && cmd_hit(cmd, CMD_SCAN, MSK_HI4);
   assign is_page = wr_cmd && cmd_hit(cmd, CMD_PAGE, MSK_HI4);
   assign is_colh = wr_cmd && cmd_hit(cmd, CMD_COLH, MSK_HI4);
   assign is_coll = wr_cmd && cmd_hit(cmd, CMD_COLL, MSK_HI4);
   assign is_pwr  = wr_cmd && cmd_hit(cmd, CMD_PWR, MSK_HI5);
   assign is_ctr  = wr_cmd && cmd_hit(cmd, CMD_CTR, MSK_HI3);
   assign is_line = wr_cmd && cmd_hit(cmd, CMD_LINE, MSK_HI2);

   // display mode bits
   logic disp_on_ff;
   logic rev_ff;
   logic all_on_ff;
   logic ind_ff;

   always_ff @(posedge CLK) begin
      if (RST) begin
         disp_on_ff <= 1'b0;
         rev_ff     <= 1'b0;
         all_on_ff  <= 1'b0;
      end else begin
         if (is_disp) begin
            disp_on_ff <= cmd[BIT_D]; // see RULE_23
         end
         if (is_rev) begin
            rev_ff <= cmd[BIT_D]; // see RULE_01
         end
         if (is_all) begin
            all_on_ff <= cmd[BIT_D]; // see RULE_02
         end
      end
   end

   // only its own command touches the indicator
   always_ff @(posedge CLK) begin
      if (RST) begin
         ind_ff <= 1'b0;
      end else if (is_ind) begin
         ind_ff <= cmd[BIT_D]; // see RULE_15
      end
   end

   // power circuits; soft reset deliberately absent here
   logic [2:0] pwr_ff;
   logic [4:0] ctr_ff;
   logic       bias_ff;

   always_ff @(posedge CLK) begin
      if (RST) begin
         pwr_ff <= PWR_RST; // see RULE_11
         ctr_ff <= CTR_RST;
      end else begin
         if (is_pwr) begin
            pwr_ff <= cmd[2:0]; // see RULE_13
         end
         if (is_ctr) begin
            ctr_ff <= cmd[4:0]; // see RULE_14
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bias_ff <= 1'b0;
      end else if (is_bias && BIAS_SEL_OK && FOLLOWER_EN) begin
         bias_ff <= cmd[BIT_D]; // see RULE_04, see RULE_05
      end
   end

   // addressing: line, page, scan direction
   logic [5:0] line_ff;
   logic [3:0] page_ff;
   logic       scan_ff;

   always_ff @(posedge CLK) begin
      if (RST || is_srst) begin
         line_ff <= LINE_RST; // see RULE_10
         page_ff <= PAGE_RST;
         scan_ff <= 1'b0;
      end else begin
         if (is_line) begin
            line_ff <= cmd[5:0];
         end
         if (is_page) begin
            page_ff <= cmd[3:0];
         end
         if (is_scan && SCAN_SEL_OK) begin
            scan_ff <= cmd[BIT_SCAN]; // see RULE_12
         end
      end
   end

   // column counter and read-modify-write
   logic [7:0] col_ff;
   logic [7:0] nxt_col;
   logic [7:0] col_save_ff;
   logic       rmw_ff;

   always_comb begin
      nxt_col = (col_ff == COL_MAX) ? col_ff : col_ff + 8'h01;
   end

   always_ff @(posedge CLK) begin
      if (RST || is_srst) begin
         col_ff <= COL_RST; // see RULE_10
      end else if (is_end && rmw_ff) begin
         col_ff <= col_save_ff; // see RULE_07
      end else if (is_colh) begin
         col_ff <= {cmd[3:0], col_ff[3:0]};
      end else if (is_coll) begin
         col_ff <= {col_ff[7:4], cmd[3:0]};
      end else if (wr_dat || (rd_dat && !rmw_ff)) begin
         col_ff <= nxt_col; // see RULE_06
      end
   end

   // other commands pass through without leaving the mode
   always_ff @(posedge CLK) begin
      if (RST) begin
         rmw_ff      <= 1'b0;
         col_save_ff <= COL_RST;
      end else if (is_rmw) begin
         rmw_ff      <= 1'b1; // see RULE_08
         col_save_ff <= col_ff; // see RULE_07
      end else if (is_end) begin
         rmw_ff <= 1'b0; // see RULE_07
      end
   end

   // power-save state
   lcdcd_ps_t ps_ff;
   logic      seen_off_ff;
   logic      seen_ind_ff;
   logic      ps_off;

   // power-save-off: display on, or all-pixels back to normal
   assign ps_off = (is_disp && cmd[BIT_D]) || (is_all && !cmd[BIT_D]);

   always_ff @(posedge CLK) begin
      if (RST) begin
         ps_ff <= PS_ON;
      end else begin
         unique case (ps_ff)
            PS_ON: begin
               if (is_all && cmd[BIT_D] && !disp_on_ff) begin
                  ps_ff <= ind_ff ? PS_STBY : PS_SLEEP; // see RULE_17, see RULE_18
               end
            end
            PS_SLEEP: begin
               if ((ps_off || seen_off_ff) && ((is_ind && cmd[BIT_D]) || seen_ind_ff)) begin
                  ps_ff <= PS_ON; // see RULE_19
               end
            end
            PS_STBY: begin
               if (is_srst) begin
                  ps_ff <= PS_SLEEP; // see RULE_22
               end else if (ps_off) begin
                  ps_ff <= PS_ON; // see RULE_20
               end
            end
         endcase
      end
   end

   // release halves may come in either order while asleep
   always_ff @(posedge CLK) begin
      if (RST || ps_ff != PS_SLEEP) begin
         seen_off_ff <= 1'b0;
         seen_ind_ff <= 1'b0;
      end else begin
         if (ps_off) begin
            seen_off_ff <= 1'b1;
         end
         if (is_ind && cmd[BIT_D]) begin
            seen_ind_ff <= 1'b1;
         end
      end
   end

   // indicator blink divider
   lcdcd_blink_if bif ();

   lcdcd_blink #(
      .HALF_CYC (BLINK_HALF)
   ) lcdcd_blink_inst (
      .CLK (CLK),
      .RST (RST),
      .bi  (bif)
   );

   logic active;

   assign active  = (ps_ff == PS_ON);
   assign bif.run = ind_ff && OSC_EN; // see RULE_16

   // panel and supply outputs; ram and settings survive power save
   assign OSC_EN           = (ps_ff != PS_SLEEP); // see RULE_21
   assign BOOSTER_EN       = pwr_ff[PWR_BST] && active;
   assign REGULATOR_EN     = pwr_ff[PWR_REG] && active;
   assign FOLLOWER_EN      = pwr_ff[PWR_FOL] && active;
   assign DUTY_DRIVE_EN    = disp_on_ff && active;
   assign PIXEL_ALL_ON     = all_on_ff && active; // see RULE_02
   assign PIXEL_INVERT     = rev_ff && !PIXEL_ALL_ON; // see RULE_03
   assign STATIC_IND_DRIVE = bif.run && bif.phase;
   assign BIAS_SEL         = bias_ff;
   assign CONTRAST         = ctr_ff;
   assign CONTRAST_EN      = (ctr_ff != CTR_RST); // see RULE_14
   assign COM_SCAN_REV     = scan_ff;
   assign SLEEP            = (ps_ff == PS_SLEEP);
   assign STANDBY          = (ps_ff == PS_STBY);
   assign RAM_WR_STB       = wr_dat;
   assign RAM_RD_STB       = rd_dat;
   assign RAM_WDATA        = HWDATA[7:0];
   assign RAM_COL          = col_ff;
   assign RAM_PAGE         = page_ff;
   assign START_LINE       = line_ff;

   // read mux, unmapped reads as zero
   always_comb begin
      HRDATA = 32'h00000000;
      if (sel_ff && !wr_ff) begin
         unique case (addr_ff)
            OFS_DATA:   HRDATA = {24'h000000, RAM_RDATA};
            OFS_STATUS: HRDATA = {20'h00000, ps_ff, pwr_ff, scan_ff, rmw_ff,
                                  bias_ff, ind_ff, all_on_ff, rev_ff, disp_on_ff};
            OFS_ADDR:   HRDATA = {9'h000, ctr_ff, line_ff, page_ff, col_ff};
            default:    HRDATA = 32'h00000000;
         endcase
      end
   end

   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence s_ps_entry;
      is_all && cmd[BIT_D] && !disp_on_ff && active;
   endsequence

   sequence s_rmw_end;
      rmw_ff && is_end;
   endsequence

   sequence s_stby_reset;
      STANDBY && is_srst;
   endsequence

   a_reverse_pixels: assert property ( // see RULE_01
      is_rev && cmd[BIT_D] && !all_on_ff |=> PIXEL_INVERT [*2])
      else $error("reverse command did not invert pixels");

   a_allon_override: assert property ( // see RULE_03
      is_all && cmd[BIT_D] && active && disp_on_ff |=> PIXEL_ALL_ON && !PIXEL_INVERT)
      else $error("all-on did not override polarity");

   a_bias_gated: assert property ( // see RULE_05
      is_bias && !FOLLOWER_EN |=> BIAS_SEL == $past(BIAS_SEL))
      else $error("bias changed with follower off");

   a_rmw_read_hold: assert property ( // see RULE_06
      rmw_ff && rd_dat |=> RAM_COL == $past(RAM_COL))
      else $error("column moved on read during rmw");

   a_rmw_save: assert property ( // see RULE_07
      is_rmw |=> col_save_ff == $past(col_ff) && rmw_ff)
      else $error("rmw entry did not save column");

   a_rmw_restore: assert property ( // see RULE_07
      s_rmw_end |=> RAM_COL == $past(col_save_ff) && !rmw_ff)
      else $error("end did not restore saved column");

   a_rmw_stays: assert property ( // see RULE_08
      rmw_ff && wr_cmd && !is_end |=> rmw_ff)
      else $error("rmw left on another command");

   a_soft_reset: assert property ( // see RULE_10
      is_srst |=> RAM_COL == COL_RST && RAM_PAGE == PAGE_RST && START_LINE == LINE_RST
         && !COM_SCAN_REV && pwr_ff == $past(pwr_ff))
      else $error("soft reset result wrong");

   a_scan_bit: assert property ( // see RULE_12
      is_scan |=> COM_SCAN_REV == $past(cmd[BIT_SCAN]))
      else $error("scan direction not from bit 3");

   a_contrast_load: assert property ( // see RULE_14
      is_ctr |=> CONTRAST == $past(cmd[4:0]) && CONTRAST_EN == ($past(cmd[4:0]) != 5'h00))
      else $error("contrast load wrong");

   a_ind_only: assert property ( // see RULE_15
      wr_cmd && !is_ind |=> ind_ff == $past(ind_ff))
      else $error("indicator changed by other command");

   a_ps_entry: assert property ( // see RULE_18
      s_ps_entry |=> ($past(ind_ff) ? STANDBY : SLEEP) && !PIXEL_ALL_ON)
      else $error("power save entry state wrong");

   a_stby_sleep: assert property ( // see RULE_22
      s_stby_reset |=> SLEEP)
      else $error("reset in standby did not sleep");

   a_sleep_quiet: assert property ( // see RULE_21
      SLEEP |-> !OSC_EN && !BOOSTER_EN && !REGULATOR_EN && !FOLLOWER_EN && !STATIC_IND_DRIVE
         && !DUTY_DRIVE_EN)
      else $error("sleep left circuits running");

endmodule : lcdcd_top

// ===== verilog/lcdcd_pkg.sv
// constants for the lcd command decoder: bus map, command codes, resets
// assumes a 25 MHz system clock and word-aligned ahb-lite accesses
package lcdcd_pkg;

   // clock and blink timing
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CMD    = 8'h00;
   localparam logic [7:0] OFS_DATA   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_ADDR   = 8'h0c;

   // htrans codes
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [1:0] TRANS_SEQ    = 2'h3;

   // command codes and masks
   localparam logic [7:0] CMD_DISP   = 8'hae;
   localparam logic [7:0] CMD_REV    = 8'ha6;
   localparam logic [7:0] CMD_ALLON  = 8'ha4;
   localparam logic [7:0] CMD_BIAS   = 8'ha2;
   localparam logic [7:0] CMD_IND    = 8'hac;
   localparam logic [7:0] MSK_D0     = 8'hfe;
   localparam logic [7:0] CMD_RMW    = 8'he0;
   localparam logic [7:0] CMD_END    = 8'hee;
   localparam logic [7:0] CMD_SRST   = 8'he2;
   localparam logic [7:0] MSK_ALL    = 8'hff;
   localparam logic [7:0] CMD_SCAN   = 8'hc0;
   localparam logic [7:0] CMD_PAGE   = 8'hb0;
   localparam logic [7:0] CMD_COLH   = 8'h10;
   localparam logic [7:0] CMD_COLL   = 8'h00;
   localparam logic [7:0] MSK_HI4    = 8'hf0;
   localparam logic [7:0] CMD_PWR    = 8'h28;
   localparam logic [7:0] MSK_HI5    = 8'hf8;
   localparam logic [7:0] CMD_CTR    = 8'h80;
   localparam logic [7:0] MSK_HI3    = 8'he0;
   localparam logic [7:0] CMD_LINE   = 8'h40;
   localparam logic [7:0] MSK_HI2    = 8'hc0;

   // field positions
   localparam int unsigned BIT_D     = 0;
   localparam int unsigned BIT_SCAN  = 3;
   localparam int unsigned PWR_FOL   = 0;
   localparam int unsigned PWR_REG   = 1;
   localparam int unsigned PWR_BST   = 2;

   // reset values and limits
   localparam logic [2:0] PWR_RST  = 3'h0;
   localparam logic [4:0] CTR_RST  = 5'h00;
   localparam logic [7:0] COL_RST  = 8'h00;
   localparam logic [7:0] COL_MAX  = 8'h83;
   localparam logic [3:0] PAGE_RST = 4'h0;
   localparam logic [5:0] LINE_RST = 6'h00;

   typedef enum logic [1:0] {PS_ON, PS_SLEEP, PS_STBY} lcdcd_ps_t;

   function automatic logic cmd_hit(input logic [7:0] b, input logic [7:0] code,
                                    input logic [7:0] msk);
      cmd_hit = ((b & msk) == code);
   endfunction : cmd_hit

endpackage : lcdcd_pkg

// ===== verilog/lcdcd_blink_if.sv
// link between the command decoder and its indicator blink divider
// assumes both ends sit on the same clock
interface lcdcd_blink_if;
   logic run;
   logic phase;
   modport ctl (output run, input phase);
   modport div (input run, output phase);
endinterface : lcdcd_blink_if

// ===== verilog/lcdcd_blink.sv
// indicator blink divider: toggles a phase every half period while run
// assumes run stays low whenever the oscillator is meant to be stopped
module lcdcd_blink
   import lcdcd_pkg::*;
#(
   parameter int unsigned HALF_CYC = BLINK_HALF_CYC
) (
   // clock and reset
   input  wire logic   CLK,
   input  wire logic   RST,
   // decoder side
   lcdcd_blink_if.div  bi
);

   logic [23:0] cnt_ff;
   logic        phase_ff;

   // cleared when stopped so each on starts with a full lit half
   always_ff @(posedge CLK) begin
      if (RST || !bi.run) begin
         cnt_ff <= 24'h000000;
      end else if (cnt_ff == 24'(HALF_CYC - 1)) begin
         cnt_ff <= 24'h000000;
      end else begin
         cnt_ff <= cnt_ff + 24'h000001; // see RULE_24
      end
   end

   always_ff @(posedge CLK) begin
      if (RST || !bi.run) begin
         phase_ff <= 1'b1;
      end else if (cnt_ff == 24'(HALF_CYC - 1)) begin
         phase_ff <= !phase_ff; // see RULE_16
      end
   end

   assign bi.phase = phase_ff;

endmodule : lcdcd_blink

// ===== tb/lcdcd_host.sv
// host model: issues single word ahb-lite transfers to the decoder
// assumes one slave whose hreadyout is the bus hready
module lcdcd_host
   import lcdcd_pkg::*;
(
   // clock
   input  wire logic        CLK,
   // bus master side
   output logic             HSEL,
   output logic      [7:0]  HADDR,
   output logic      [1:0]  HTRANS,
   output logic             HWRITE,
   output logic      [2:0]  HSIZE,
   output logic      [31:0] HWDATA,
   input  wire logic        HREADY,
   input  wire logic [31:0] HRDATA
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      HSEL   = 1'b0;
      HADDR  = 8'h00;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE  = 3'h2;
      HWDATA = 32'h0;
   end

   // sampled at the deciding rising edge, before the slave's flops move
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
      logic r;
      @(posedge CLK);
      HSEL   <= 1'b1;
      HADDR  <= a;
      HTRANS <= TRANS_NONSEQ;
      HWRITE <= w;
      HSIZE  <= 3'h2;
      do begin
         @(posedge CLK);
      end while (HREADY !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= w ? d : ~HWDATA;
      do begin
         @(posedge CLK);
         r = HREADY;
         q = HRDATA;
      end while (r !== 1'b1);
      // released data lines must not keep the old value
      HWDATA <= ~HWDATA;
   endtask : xfer
endmodule : lcdcd_host

// ===== tb/lcdcd_top_test.sv
// testbench for the lcd command decoder: commands go through the host
// model, panel, power and ram outputs are judged after each step
// assumes a 25 MHz clock and a blink half period shortened to 8 cycles
module lcdcd_top_test
   import lcdcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned HALF = 8;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel, hwrite, hreadyout, hresp, wr_stb, rd_stb;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr, ram_wdata, ram_col, last_wd;
   logic [7:0]  ram_rdata = 8'h5a;
   logic [31:0] hwdata, hrdata, q;
   logic [3:0]  ram_page;
   logic [5:0]  start_line;
   logic [4:0]  contrast;
   logic        inv, all_on, duty, scan_rev, ind_drv, osc;
   logic        bst, reg_en, fol, bias, ctr_en, sleep, stby;
   int          bad_count = 0;
   int          n_checks = 0;
   int          wr_cnt = 0;
   int          rd_cnt = 0;

   always #20 clk = ~clk;

   // strobes are combinational in the data phase: count them mid-cycle
   always @(negedge clk) begin
      if (wr_stb === 1'b1) begin
         wr_cnt++;
         last_wd = ram_wdata;
      end
      if (rd_stb === 1'b1) begin
         rd_cnt++;
      end
   end

   lcdcd_top #(.BLINK_HALF(HALF)) lcdcd_top_inst (
      .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .RAM_WR_STB(wr_stb), .RAM_RD_STB(rd_stb), .RAM_WDATA(ram_wdata),
      .RAM_RDATA(ram_rdata), .RAM_COL(ram_col), .RAM_PAGE(ram_page),
      .START_LINE(start_line), .PIXEL_INVERT(inv), .PIXEL_ALL_ON(all_on),
      .DUTY_DRIVE_EN(duty), .COM_SCAN_REV(scan_rev), .STATIC_IND_DRIVE(ind_drv),
      .OSC_EN(osc), .BOOSTER_EN(bst), .REGULATOR_EN(reg_en), .FOLLOWER_EN(fol),
      .BIAS_SEL(bias), .CONTRAST(contrast), .CONTRAST_EN(ctr_en),
      .SLEEP(sleep), .STANDBY(stby));

   lcdcd_host lcdcd_host_inst (
      .CLK(clk), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata));

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("FAIL %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask : chk

   task automatic cmd(input logic [7:0] b);
      lcdcd_host_inst.xfer(OFS_CMD, 1'b1, {24'h0, b}, q);
      #1;
   endtask : cmd

   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
      lcdcd_host_inst.xfer(a, w, {24'h0, d}, q);
      #1;
   endtask : acc

   task automatic t_bus;
      acc(8'h10, 1'b0, 8'h00);
      chk("unmapped read", 32'h0, q);
      acc(OFS_STATUS, 1'b1, 8'hff);
      acc(OFS_STATUS, 1'b0, 8'h00);
      chk("status after reset", 32'h0, q);
      chk("hresp", 32'h0, {31'h0, hresp});
      $display("bus test done");
   endtask : t_bus

   task automatic t_pol;
      int w0;
      w0 = wr_cnt;
      cmd(CMD_DISP | 8'h01);
      chk("duty on", 32'h1, {31'h0, duty});
      cmd(CMD_REV | 8'h01);
      chk("invert", 32'h1, {31'h0, inv});
      cmd(CMD_ALLON | 8'h01);
      chk("all on", 32'h1, {31'h0, all_on});
      chk("invert under all on", 32'h0, {31'h0, inv});
      cmd(CMD_ALLON);
      chk("invert back", 32'h1, {31'h0, inv});
      cmd(CMD_REV);
      chk("normal", 32'h0, {31'h0, inv});
      chk("ram untouched", w0, wr_cnt);
      $display("polarity test done");
   endtask : t_pol

   task automatic t_pwr;
      cmd(CMD_PWR);
      cmd(CMD_BIAS | 8'h01);
      chk("bias, follower off", 32'h0, {31'h0, bias});
      for (int n = 0; n < 8; n++) begin
         cmd(CMD_PWR | 8'(n));
         chk("power stages", n, {29'h0, bst, reg_en, fol});
      end
      cmd(CMD_BIAS | 8'h01);
      chk("bias set", 32'h1, {31'h0, bias});
      cmd(CMD_BIAS);
      chk("bias clear", 32'h0, {31'h0, bias});
      $display("power test done");
   endtask : t_pwr

   task automatic t_ctr;
      logic [4:0] v [3] = '{5'h00, 5'h1f, 5'h01};
      foreach (v[i]) begin
         cmd(CMD_CTR | {3'h0, v[i]});
         chk("contrast", v[i], contrast);
         chk("contrast enable", v[i] != 5'h00, ctr_en);
      end
      $display("contrast test done");
   endtask : t_ctr

   task automatic t_rmw;
      int r0;
      cmd(CMD_COLH | 8'h01);
      cmd(CMD_COLL | 8'h05);
      r0 = rd_cnt;
      cmd(CMD_RMW);
      acc(OFS_DATA, 1'b0, 8'h00);
      chk("ram read data", 32'h5a, q);
      acc(OFS_DATA, 1'b0, 8'h00);
      chk("column on rmw reads", 32'h15, ram_col);
      acc(OFS_DATA, 1'b1, 8'h3c);
      chk("column on rmw write", 32'h16, ram_col);
      chk("ram write data", 32'h3c, last_wd);
      cmd(CMD_REV | 8'h01);
      acc(OFS_STATUS, 1'b0, 8'h00);
      chk("rmw kept", 32'h1, q[5]);
      chk("command in rmw", 32'h1, {31'h0, inv});
      cmd(CMD_REV);
      cmd(CMD_END);
      chk("column restored", 32'h15, ram_col);
      acc(OFS_STATUS, 1'b0, 8'h00);
      chk("rmw left", 32'h0, q[5]);
      acc(OFS_DATA, 1'b0, 8'h00);
      chk("column on plain read", 32'h16, ram_col);
      chk("read strobes", r0 + 3, rd_cnt);
      $display("rmw test done");
   endtask : t_rmw

   task automatic t_srst;
      cmd(CMD_LINE | 8'h2a);
      cmd(CMD_PAGE | 8'h03);
      cmd(CMD_SCAN | 8'h07);
      chk("scan low bits", 32'h0, {31'h0, scan_rev});
      cmd(CMD_SCAN | 8'h08);
      chk("scan reverse", 32'h1, {31'h0, scan_rev});
      chk("line", 32'h2a, start_line);
      chk("page", 32'h3, ram_page);
      cmd(CMD_SRST);
      chk("line reset", 32'h0, start_line);
      chk("page reset", 32'h0, ram_page);
      chk("column reset", 32'h0, ram_col);
      chk("scan reset", 32'h0, {31'h0, scan_rev});
      chk("power kept", 32'h7, {29'h0, bst, reg_en, fol});
      $display("soft reset test done");
   endtask : t_srst

   task automatic t_ind;
      int n;
      cmd(CMD_IND | 8'h01);
      @(negedge clk);
      for (int p = 1; p >= 0; p--) begin
         n = 0;
         while (ind_drv === p[0] && n < 40) begin
            n++;
            @(negedge clk);
         end
         chk("blink half period", HALF, n);
      end
      cmd(CMD_DISP);
      cmd(CMD_DISP | 8'h01);
      cmd(CMD_REV | 8'h01);
      cmd(CMD_REV);
      acc(OFS_STATUS, 1'b0, 8'h00);
      chk("indicator kept", 32'h1, q[3]);
      cmd(CMD_IND);
      chk("indicator off", 32'h0, {31'h0, ind_drv});
      $display("indicator test done");
   endtask : t_ind

   task automatic t_ps;
      int w0;
      cmd(CMD_ALLON | 8'h01);
      chk("all on, display on", 32'h2, {30'h0, all_on, sleep});
      cmd(CMD_ALLON);
      cmd(CMD_DISP);
      cmd(CMD_ALLON | 8'h01);
      chk("sleep entry", 32'h2, {30'h0, sleep, stby});
      chk("sleep drive", 32'h0, {27'h0, all_on, duty, osc, bst, fol});
      w0 = wr_cnt;
      acc(OFS_DATA, 1'b1, 8'hc3);
      chk("ram access in sleep", w0 + 1, wr_cnt);
      acc(OFS_STATUS, 1'b0, 8'h00);
      chk("power mode kept", 32'h7, q[9:7]);
      cmd(CMD_DISP | 8'h01);
      chk("sleep half released", 32'h1, {31'h0, sleep});
      cmd(CMD_IND | 8'h01);
      chk("sleep released", 32'h3, {30'h0, osc, !sleep});
      cmd(CMD_ALLON);
      cmd(CMD_DISP);
      cmd(CMD_ALLON | 8'h01);
      chk("standby entry", 32'h5, {29'h0, stby, sleep, osc});
      cmd(CMD_SRST);
      chk("standby to sleep", 32'h2, {30'h0, sleep, stby});
      cmd(CMD_ALLON);
      cmd(CMD_IND | 8'h01);
      chk("sleep released again", 32'h0, {30'h0, sleep, stby});
      cmd(CMD_ALLON | 8'h01);
      chk("standby again", 32'h1, {30'h0, sleep, stby});
      cmd(CMD_ALLON);
      chk("standby released", 32'h0, {30'h0, sleep, stby});
      $display("power save test done");
   endtask : t_ps

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // whole run takes well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_bus();
      t_pol();
      t_pwr();
      t_ctr();
      t_rmw();
      t_srst();
      t_ind();
      t_ps();
      end_of_test();
   end
endmodule : lcdcd_top_test
